// ===== src/gpd_pkg.sv
package gpd_pkg;

	localparam int NPORT = 8;
	localparam int NPIN = 8;
	localparam int ADDR_W = 15;

	// Each port owns a 4 KB window; port index sits above the in-window offset
	localparam int PORT_SEL_LSB = 12;
	localparam int PORT_SEL_W = 3;
	localparam int MASK_LSB = 2;
	localparam int MASK_MSB = 9;

	localparam logic [11:0] OFF_DATA_LAST = 12'h3FC;
	localparam logic [11:0] OFF_DIR = 12'h400;
	localparam logic [11:0] OFF_AFSEL = 12'h404;
	localparam logic [11:0] OFF_PUR = 12'h408;
	localparam logic [11:0] OFF_PDR = 12'h40C;
	localparam logic [11:0] OFF_DEN = 12'h410;
	localparam logic [11:0] OFF_PIN = 12'h414;

	localparam logic [7:0] RST_DATA = 8'h00;
	localparam logic [7:0] RST_DIR = 8'h00;
	localparam logic [7:0] RST_CFG_OFF = 8'h00;
	localparam logic [2:0] DBG_PORT_B = 3'h1;
	localparam logic [2:0] DBG_PORT_C = 3'h2;
	localparam logic [7:0] DBG_MASK_B = 8'h80;
	localparam logic [7:0] DBG_MASK_C = 8'h0F;
	localparam int TRST_BIT = 7;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0] pwdata;
		logic [3:0] pstrb;
	} gpd_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} gpd_apb_rsp_t;

	typedef struct packed {
		logic [7:0] data;
		logic [7:0] dir;
		logic [7:0] afsel;
		logic [7:0] pur;
		logic [7:0] pdr;
		logic [7:0] den;
	} gpd_cfg_t;

	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
		logic [7:0] pu;
		logic [7:0] pd;
		logic [7:0] den;
	} gpd_pad_t;

	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
	} gpd_alt_t;

	// Pins that come out of reset owned by the debug port
	function automatic logic [7:0] gpd_debug_mask(input logic [2:0] port);
		logic [7:0] m;
		m = 8'h00;
		if (port == DBG_PORT_B)
			m = DBG_MASK_B;
		else if (port == DBG_PORT_C)
			m = DBG_MASK_C;
		return m;
	endfunction

endpackage

// ===== src/gpd_sync.sv
`timescale 1ns/1ns
module gpd_sync
	import gpd_pkg::*;
#(
	parameter int W = 64
)(
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);

	typedef struct packed {
		logic [W-1:0] ff1;
		logic [W-1:0] ff2;
		logic [W-1:0] ff3;
		logic [W-1:0] val;
	} gpd_sync_st_t;

	gpd_sync_st_t st_q;
	gpd_sync_st_t st_d;
	logic [W-1:0] differ;

	always_comb
	begin
		st_d = st_q;
		st_d.ff1 = i_async;
		st_d.ff2 = st_q.ff1;
		st_d.ff3 = st_q.ff2;
		differ = st_q.ff2 ^ st_q.ff3;
		// A bit moves only once the second and third stages agree
		st_d.val = (~differ & st_q.ff3) | (differ & st_q.val);
	end

	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign o_sync = st_q.val;

endmodule

// ===== src/gpd_top.sv
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/1ns
module gpd_top
	import gpd_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire gpd_apb_req_t i_apb,
	output gpd_apb_rsp_t o_apb,
	input wire logic [NPORT-1:0][NPIN-1:0] i_pad_in,
	input wire gpd_alt_t [NPORT-1:0] i_alt,
	output gpd_pad_t [NPORT-1:0] o_pad,
	output logic [NPORT-1:0][NPIN-1:0] o_alt_in,
	output logic o_dbg_trst_n
);

	typedef struct packed {
		gpd_cfg_t [NPORT-1:0] cfg;
		gpd_pad_t [NPORT-1:0] pad;
		logic [31:0] prdata;
		logic slverr;
		logic trst_n;
	} gpd_state_t;

	// Reset image: every port off except the debug pins
	function automatic gpd_state_t gpd_reset_state();
		gpd_state_t s;
		logic [7:0] dm;
		s = '0;
		for (int p = 0; p < NPORT; p++)
		begin
			dm = gpd_debug_mask(PORT_SEL_W'(p));
			s.cfg[p].data = RST_DATA;
			s.cfg[p].dir = RST_DIR;
			s.cfg[p].afsel = RST_CFG_OFF | dm;
			s.cfg[p].den = RST_CFG_OFF | dm;
			s.cfg[p].pur = RST_CFG_OFF | dm;
			s.cfg[p].pdr = RST_CFG_OFF;
			s.pad[p].pu = RST_CFG_OFF | dm;
			s.pad[p].pd = RST_CFG_OFF;
			s.pad[p].den = RST_CFG_OFF | dm;
			s.pad[p].out = 8'h00;
			s.pad[p].oe = 8'h00;
		end
		s.prdata = 32'h0000_0000;
		s.slverr = 1'b0;
		s.trst_n = 1'b1;
		return s;
	endfunction

	localparam gpd_state_t ST_RST = gpd_reset_state();

	// Per-bit mask taken straight from the address: bit n uses address bit n+2
	function automatic logic [7:0] gpd_addr_mask(input logic [ADDR_W-1:0] a);
		return a[MASK_MSB:MASK_LSB];
	endfunction

	function automatic logic [7:0] gpd_merge(input logic [7:0] old_v,
			input logic [7:0] new_v, input logic [7:0] m);
		return (old_v & ~m) | (new_v & m);
	endfunction

	gpd_state_t st_q;
	gpd_state_t st_d;
	logic [NPORT-1:0][NPIN-1:0] pin_sync;

	logic setup;
	logic access;
	logic wr_en;
	logic [PORT_SEL_W-1:0] port;
	logic [11:0] off;
	logic [7:0] amask;
	logic [7:0] wbyte;
	logic [7:0] rbyte;
	logic rd_err;
	logic wr_data;
	logic wr_dir;
	logic wr_afsel;
	logic wr_pur;
	logic wr_pdr;
	logic wr_den;
	logic in_data;

	// Pads come from the board: three stages, change taken once two agree
	gpd_sync #(
		.W(NPORT * NPIN)
	) u_pin_sync (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.i_async(i_pad_in),
		.o_sync(pin_sync)
	);

	// Address decode shared by setup (read/error) and access (write)
	always_comb
	begin
		setup = i_apb.psel & ~i_apb.penable;
		access = i_apb.psel & i_apb.penable;
		port = i_apb.paddr[PORT_SEL_LSB +: PORT_SEL_W];
		off = i_apb.paddr[11:0];
		amask = gpd_addr_mask(i_apb.paddr);
		wbyte = i_apb.pwdata[7:0];
		in_data = (off <= OFF_DATA_LAST);
		wr_en = access & i_apb.pwrite & ~st_q.slverr & i_apb.pstrb[0];
		wr_data = 1'b0;
		wr_dir = 1'b0;
		wr_afsel = 1'b0;
		wr_pur = 1'b0;
		wr_pdr = 1'b0;
		wr_den = 1'b0;
		rbyte = 8'h00;
		rd_err = 1'b0;
		if (i_apb.paddr[1:0] != 2'b00)
		begin
			rd_err = 1'b1;
		end
		else if (in_data)
		begin
			rbyte = st_q.cfg[port].data & amask;
			wr_data = wr_en;
		end
		else if (off == OFF_DIR)
		begin
			rbyte = st_q.cfg[port].dir;
			wr_dir = wr_en;
		end
		else if (off == OFF_AFSEL)
		begin
			rbyte = st_q.cfg[port].afsel;
			wr_afsel = wr_en;
		end
		else if (off == OFF_PUR)
		begin
			rbyte = st_q.cfg[port].pur;
			wr_pur = wr_en;
		end
		else if (off == OFF_PDR)
		begin
			rbyte = st_q.cfg[port].pdr;
			wr_pdr = wr_en;
		end
		else if (off == OFF_DEN)
		begin
			rbyte = st_q.cfg[port].den;
			wr_den = wr_en;
		end
		else if (off == OFF_PIN)
		begin
			// Read-only view of the filtered pads; writes are accepted and dropped
			rbyte = pin_sync[port];
		end
		else
		begin
			rd_err = 1'b1;
		end
	end

	always_comb
	begin
		st_d = st_q;

		// Read data and error are latched in the setup cycle so that the
		// access cycle can complete with no wait state
		if (setup)
		begin
			st_d.slverr = rd_err;
			st_d.prdata = (i_apb.pwrite || rd_err) ? 32'h0000_0000 : {24'h000000, rbyte};
		end

		if (wr_data)
		begin
			st_d.cfg[port].data = gpd_merge(st_q.cfg[port].data, wbyte, amask);
		end
		if (wr_dir)
		begin
			st_d.cfg[port].dir = wbyte;
		end
		if (wr_afsel)
		begin
			st_d.cfg[port].afsel = wbyte;
		end
		if (wr_pur)
		begin
			st_d.cfg[port].pur = wbyte;
		end
		if (wr_pdr)
		begin
			st_d.cfg[port].pdr = wbyte;
		end
		if (wr_den)
		begin
			st_d.cfg[port].den = wbyte;
		end

		for (int p = 0; p < NPORT; p++)
		begin
			// Input bits with DEN set follow the pad every cycle (others read 0), so a
			// software write to an input bit is replaced by the capture in the same cycle
			st_d.cfg[p].data = (st_d.cfg[p].data & st_q.cfg[p].dir)
				| (pin_sync[p] & st_q.cfg[p].den & ~st_q.cfg[p].dir);

			// Output stage is registered so the pads see one clean edge
			st_d.pad[p].out = (st_q.cfg[p].afsel & i_alt[p].out)
				| (~st_q.cfg[p].afsel & st_q.cfg[p].data);
			st_d.pad[p].oe = st_q.cfg[p].den & ((st_q.cfg[p].afsel & i_alt[p].oe)
				| (~st_q.cfg[p].afsel & st_q.cfg[p].dir));
			st_d.pad[p].pu = st_q.cfg[p].pur;
			st_d.pad[p].pd = st_q.cfg[p].pdr;
			st_d.pad[p].den = st_q.cfg[p].den;
		end

		// Debug reset follows the pad only while the pin belongs to the
		// debug function; as a plain GPIO it can no longer reset the debugger
		if (st_q.cfg[DBG_PORT_B].afsel[TRST_BIT] && st_q.cfg[DBG_PORT_B].den[TRST_BIT])
		begin
			st_d.trst_n = pin_sync[DBG_PORT_B][TRST_BIT];
		end
		else
		begin
			st_d.trst_n = 1'b1;
		end
	end

	// One reset input carries both power-on and the external reset pin
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			st_q <= ST_RST;
		else
			st_q <= st_d;
	end

	always_comb
	begin
		o_apb.prdata = st_q.prdata;
		o_apb.pready = 1'b1;
		o_apb.pslverr = access & st_q.slverr;
		o_pad = st_q.pad;
		o_dbg_trst_n = st_q.trst_n;
		for (int p = 0; p < NPORT; p++)
		begin
			// Peripherals see the filtered pad only where they own the pin
			o_alt_in[p] = pin_sync[p] & st_q.cfg[p].afsel & st_q.cfg[p].den;
		end
	end

endmodule

// ===== test/gpd_top_properties.sv
`timescale 1ns/1ns
module gpd_top_properties
	import gpd_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire gpd_apb_req_t i_apb,
	input wire gpd_apb_rsp_t o_apb,
	input wire logic [NPORT-1:0][NPIN-1:0] i_pad_in,
	input wire gpd_alt_t [NPORT-1:0] i_alt,
	input wire gpd_pad_t [NPORT-1:0] o_pad,
	input wire logic [NPORT-1:0][NPIN-1:0] o_alt_in,
	input wire logic o_dbg_trst_n
);
	logic [3:0] hi_q;
	logic acc;
	logic [7:0] m;
	assign acc = i_apb.psel && i_apb.penable;
	assign m = i_apb.paddr[9:2];
	// Counts how long the test-reset pin has been high, past the filter delay
	always_ff @(posedge i_clk or negedge i_rstn)
		if (!i_rstn || !i_pad_in[1][7])
			hi_q <= 4'h0;
		else if (hi_q != 4'hF)
			hi_q <= hi_q + 4'h1;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	chk_reset_pads: assert property ($rose(i_rstn) |-> o_pad[0] == 40'h0
		&& o_pad[1].pu == 8'h80 && o_pad[2].den == 8'h0F) else $error("pad reset state");
	chk_trst_high: assert property (hi_q > 4'h7 |-> o_dbg_trst_n)
		else $error("test reset low with pin high");
	chk_trst_low: assert property (!i_pad_in[1][7] [*8] |-> !o_dbg_trst_n)
		else $error("test reset ignores low pin");
	chk_window_ok: assert property (acc && i_apb.paddr[11:10] == 2'h0
		&& i_apb.paddr[1:0] == 2'h0 |-> !o_apb.pslverr) else $error("data window refused");
	chk_read_mask: assert property (acc && !i_apb.pwrite && i_apb.paddr[11:10] == 2'h0
		|-> (o_apb.prdata & ~{24'h0, m}) == 32'h0) else $error("masked read bits");
	chk_write_mask: assert property (acc && i_apb.pwrite && i_apb.pstrb[0]
		&& i_apb.paddr[14:10] == 5'h0 && i_apb.paddr[1:0] == 2'h0 && o_pad[0].oe == 8'hFF
		|-> ##2 o_pad[0].out == (($past(o_pad[0].out, 2) & ~$past(m, 2))
		| ($past(i_apb.pwdata[7:0], 2) & $past(m, 2)))) else $error("masked write");
	chk_alt_drive: assert property ($past(i_rstn) && $stable(i_alt[1].out[7])
		|-> o_pad[1].out[7] == i_alt[1].out[7]) else $error("peripheral drive");
	chk_pull_quiet: assert property ($changed(o_pad[3].pu)
		|-> $past(acc && i_apb.pwrite, 2)) else $error("pull changed unasked");
endmodule
bind gpd_top gpd_top_properties chk (.i_clk(i_clk), .i_rstn(i_rstn), .i_apb(i_apb),
	.o_apb(o_apb), .i_pad_in(i_pad_in), .i_alt(i_alt), .o_pad(o_pad),
	.o_alt_in(o_alt_in), .o_dbg_trst_n(o_dbg_trst_n));

// ===== test/gpd_board.sv
`timescale 1ns/1ns
module gpd_board
	import gpd_pkg::*;
(
	input wire logic i_clk,
	input wire gpd_pad_t [NPORT-1:0] i_pad,
	input wire logic [NPORT-1:0][NPIN-1:0] i_ext_val,
	input wire logic [NPORT-1:0][NPIN-1:0] i_ext_en,
	output logic [NPORT-1:0][NPIN-1:0] o_level
);
	// An undriven pin wanders, so nothing can rely on a stale level
	logic flt_q = 1'b0;
	// Plain always: the initialiser above is this variable's start value
	always @(posedge i_clk)
		flt_q <= ~flt_q;
	always_comb
		for (int p = 0; p < NPORT; p++)
			for (int n = 0; n < NPIN; n++)
				if (i_pad[p].oe[n])
					o_level[p][n] = i_pad[p].out[n];
				else if (i_ext_en[p][n])
					o_level[p][n] = i_ext_val[p][n];
				else if (i_pad[p].pu[n] | i_pad[p].pd[n])
					o_level[p][n] = i_pad[p].pu[n];
				else
					o_level[p][n] = flt_q;
endmodule

// ===== test/gpio_port_data_direction_test.sv
`timescale 1ns/1ns
module gpio_port_data_direction_test;
	import gpd_pkg::*;
	logic i_clk = 1'b0;
	logic i_rstn = 1'b0;
	gpd_apb_req_t req = '0;
	gpd_apb_rsp_t rsp;
	gpd_alt_t [NPORT-1:0] alt = '0;
	logic [NPORT-1:0][NPIN-1:0] lvl;
	logic [NPORT-1:0][NPIN-1:0] xv = '0;
	logic [NPORT-1:0][NPIN-1:0] xe = '0;
	gpd_pad_t [NPORT-1:0] pad;
	logic trst;
	logic [NPORT-1:0][NPIN-1:0] ain;
	int bad_count = 0;
	int checks = 0;
	logic [31:0] rd;
	logic [47:0] rows [5];
	always #4 i_clk = ~i_clk;
	gpd_top uut (.i_clk(i_clk), .i_rstn(i_rstn), .i_apb(req), .o_apb(rsp), .i_pad_in(lvl),
		.i_alt(alt), .o_pad(pad), .o_alt_in(ain), .o_dbg_trst_n(trst));
	gpd_board brd (.i_clk(i_clk), .i_pad(pad), .i_ext_val(xv), .i_ext_en(xe), .o_level(lvl));
	task final_report;
		if (bad_count == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [14:0] a, input logic [7:0] d);
		int n;
		@(posedge i_clk);
		req <= '{1'b1, 1'b0, w, a, {24'h0, d}, 4'hF};
		@(posedge i_clk);
		req.penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge i_clk);
			n++;
		end
		while (rsp.pready !== 1'b1 && n < 20);
		rd = {rsp.prdata[31:1], rsp.prdata[0] | (rsp.pslverr === 1'b1 && w)};
		if (!w && rsp.pslverr === 1'b1)
			rd = 32'hEEEEEEEE;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		if (n >= 20)
		begin
			bad_count++;
			final_report();
		end
	endtask
	initial
	begin
		rows[0] = {12'h098, 8'hEB, 12'h3FC, 8'h22, 8'h22};
		rows[1] = {12'h3FC, 8'h5A, 12'h0C4, 8'h10, 8'h5A};
		rows[2] = {12'h004, 8'h01, 12'h008, 8'h02, 8'h5B};
		rows[3] = {12'h200, 8'hFF, 12'h200, 8'h80, 8'hDB};
		rows[4] = {12'h000, 8'hFF, 12'h3FC, 8'hDB, 8'hDB};
		repeat (20) @(posedge i_clk);
		i_rstn <= 1'b1;
		cmp(pad[1].pu, 8'h80);
		cmp(pad[2].den, 8'h0F);
		apb(1'b1, 15'h0400, 8'hFF);
		apb(1'b1, 15'h0410, 8'hFF);
		foreach (rows[i])
		begin
			apb(1'b1, {3'h0, rows[i][47:36]}, rows[i][35:28]);
			apb(1'b0, {3'h0, rows[i][27:16]}, 8'h00);
			cmp(rd, rows[i][15:8]);
			cmp(pad[0].out, rows[i][7:0]);
		end
		for (int n = 0; n < 8; n++)
		begin
			apb(1'b1, 15'h03FC, 8'h00);
			apb(1'b1, 15'h0004 << n, 8'hFF);
			apb(1'b0, 15'h03FC, 8'h00);
			cmp(rd, 32'h1 << n);
		end
		xv[3] <= 8'hA5;
		xe[3] <= 8'hFF;
		apb(1'b1, 15'h3410, 8'hFF);
		apb(1'b1, 15'h3408, 8'h0F);
		repeat (8) @(posedge i_clk);
		apb(1'b0, 15'h33FC, 8'h00);
		cmp(rd, 32'hA5);
		cmp(pad[0].out, 8'h80);
		apb(1'b1, 15'h340C, 8'hF0);
		repeat (2) @(posedge i_clk);
		cmp(pad[3].pd, 8'hF0);
		cmp(pad[3].pu, 8'h0F);
		apb(1'b0, 15'h0500, 8'h00);
		cmp(rd, 32'hEEEEEEEE);
		xe[1][7] <= 1'b1;
		repeat (10) @(posedge i_clk);
		cmp(trst, 1'b0);
		xe[1][7] <= 1'b0;
		alt[1] <= {8'h80, 8'h80};
		repeat (10) @(posedge i_clk);
		cmp(trst, 1'b1);
		cmp(pad[1].oe, 8'h80);
		cmp(ain[1], 8'h80);
		cmp(ain[0], 8'h00);
		i_rstn <= 1'b0;
		repeat (2) @(posedge i_clk);
		cmp(pad[0].oe, 8'h00);
		i_rstn <= 1'b1;
		apb(1'b0, 15'h0400, 8'h00);
		cmp(rd, 32'h0);
		final_report();
	end
	initial
	begin
		#400000;
		bad_count++;
		final_report();
	end
endmodule
